// [rtl/uart_rx_pkg.sv]
// shared constants, types and helpers of the oversampling serial receiver
package uart_rx_pkg;

	// register byte offsets
	localparam logic [7:0] ctrl_offset   = 8'h00;
	localparam logic [7:0] baud_offset   = 8'h04;
	localparam logic [7:0] status_offset = 8'h08;
	localparam logic [7:0] mask_offset   = 8'h0c;
	localparam logic [7:0] data_offset   = 8'h10;

	// control register field positions
	localparam int ctrl_rx_enable_bit  = 0;
	localparam int ctrl_double_bit     = 1;
	localparam int ctrl_parity_en_bit  = 2;
	localparam int ctrl_parity_odd_bit = 3;
	localparam int ctrl_char_lsb       = 4;
	localparam int ctrl_char_msb       = 6;

	// baud register field positions
	localparam int baud_select_lsb = 0;
	localparam int baud_select_msb = 11;
	localparam int baud_scale_lsb  = 12;
	localparam int baud_scale_msb  = 15;

	// status and mask bit positions
	localparam int stat_complete_bit = 0;
	localparam int stat_frame_bit    = 1;
	localparam int stat_parity_bit   = 2;
	localparam int stat_overflow_bit = 3;
	localparam int stat_full_bit     = 4;

	// values after reset
	localparam logic [2:0]  char_size_reset = 3'h3;
	localparam logic [11:0] baud_sel_reset  = 12'h000;
	localparam logic [3:0]  baud_scale_reset = 4'h0;
	localparam logic [3:0]  mask_reset      = 4'h0;

	// samples per bit and first voting sample, per speed mode
	localparam logic [4:0] samples_normal    = 5'h10;
	localparam logic [4:0] samples_double    = 5'h08;
	localparam logic [4:0] first_vote_normal = 5'h08;
	localparam logic [4:0] first_vote_double = 5'h04;
	localparam logic [4:0] vote_span         = 5'h02;

	// character sizes: field value 0 gives 5 bits, 4 and above give 9
	localparam logic [3:0] min_char_bits = 4'h5;
	localparam logic [3:0] max_char_bits = 4'h9;

	// fractional accumulator width
	localparam int frac_width = 8;

	typedef enum logic [2:0] {
		rx_idle,
		rx_start,
		rx_data,
		rx_parity,
		rx_stop
	} rx_state_t;

	function automatic logic maj3(input logic a, input logic b, input logic c);
		maj3 = (a & b) | (a & c) | (b & c);
	endfunction

endpackage

// [rtl/baud_tick_gen.sv]
// fractional baud generator producing one tick per receive sample
`timescale 1ns/10ps
module baud_tick_gen (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        enable,
	input  wire logic [11:0] baud_select_value,
	input  wire logic [3:0]  scale,
	output logic             tick
);

	typedef struct packed {
		logic [19:0]                       cnt;
		logic [uart_rx_pkg::frac_width-1:0] acc;
		logic                              tick;
	} gen_state_t;

	gen_state_t s_reg;
	gen_state_t s_next;

	always_comb begin
		logic [3:0]  k;
		logic [11:0] frac_bits;
		logic [7:0]  frac_add;
		logic [8:0]  sum;
		k = 4'h0;
		frac_bits = 12'h000;
		frac_add = 8'h00;
		sum = 9'h000;
		s_next = s_reg;
		s_next.tick = 1'b0;
		if (!enable) begin
			s_next.cnt = 20'h00000;
			s_next.acc = '0;
		end else if (s_reg.cnt == 20'h00000) begin
			// period is select+1 cycles per sample at scale 0, so select 0 gives 160 cycles per normal-speed ten-bit frame
			s_next.tick = 1'b1;
			if (!scale[3]) begin
				s_next.cnt = 20'(baud_select_value) << scale[2:0];
			end else begin
				// negative scale: the fraction is accumulated and a carry stretches one period by a cycle
				k = 4'(-scale);
				frac_bits = baud_select_value & 12'((12'h001 << k) - 12'h001);
				frac_add = 8'(frac_bits << (4'h8 - k));
				sum = {1'b0, s_reg.acc} + {1'b0, frac_add};
				s_next.acc = sum[7:0];
				s_next.cnt = 20'(baud_select_value >> k) + 20'(sum[8]);
			end
		end else begin
			s_next.cnt = s_reg.cnt - 20'h00001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tick = s_reg.tick;

endmodule

// [rtl/center_vote.sv]
// keeps the centre samples of a bit and gives their two-of-three vote
`timescale 1ns/10ps
module center_vote (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic shift_en,
	input  wire logic din,
	output logic      vote
);

	typedef struct packed {
		logic [1:0] samples;
	} vote_state_t;

	vote_state_t s_reg;
	vote_state_t s_next;

	always_comb begin
		s_next = s_reg;
		if (shift_en) begin
			s_next.samples = {s_reg.samples[0], din};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// the third sample is the one arriving in the deciding cycle itself
	assign vote = uart_rx_pkg::maj3(s_reg.samples[1], s_reg.samples[0], din);

endmodule

// [rtl/async_rx_clock_data_recovery.sv]
// oversampling asynchronous receiver with apb registers and interrupt
`timescale 1ns/10ps
module async_rx_clock_data_recovery (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rxd,
	output logic             irq
);

	typedef struct packed {
		logic                   rx_meta;
		logic                   rx_sync;
		logic                   last_sample;
		uart_rx_pkg::rx_state_t state;
		logic [4:0]             cnt;
		logic [3:0]             bit_idx;
		logic [8:0]             shift;
		logic                   par_bit;
		logic                   rx_en;
		logic                   dbl;
		logic                   par_en;
		logic                   par_odd;
		logic [2:0]             csize;
		logic [11:0]            baud_sel;
		logic [3:0]             scale;
		logic [3:0]             status;
		logic [3:0]             mask;
		logic [8:0]             rx_buf;
		logic                   buf_full;
		logic [31:0]            prdata;
		logic                   pready;
		logic                   pslverr;
		logic                   irq;
	} rx_top_state_t;

	rx_top_state_t s_reg;
	rx_top_state_t s_next;

	logic sample_tick;
	logic vote;
	logic in_window;

	function automatic logic is_mapped(input logic [7:0] addr);
		is_mapped = (addr == uart_rx_pkg::ctrl_offset) || (addr == uart_rx_pkg::baud_offset) ||
			(addr == uart_rx_pkg::status_offset) || (addr == uart_rx_pkg::mask_offset) ||
			(addr == uart_rx_pkg::data_offset);
	endfunction

	function automatic logic [3:0] char_bits(input logic [2:0] field);
		if (field > 3'h4) begin
			char_bits = uart_rx_pkg::max_char_bits;
		end else begin
			char_bits = uart_rx_pkg::min_char_bits + {1'b0, field};
		end
	endfunction

	baud_tick_gen u_baud (
		.pclk              (pclk),
		.presetn           (presetn),
		.enable            (s_reg.rx_en),
		.baud_select_value (s_reg.baud_sel),
		.scale             (s_reg.scale),
		.tick              (sample_tick)
	);

	center_vote u_vote (
		.pclk     (pclk),
		.presetn  (presetn),
		.shift_en (sample_tick & in_window),
		.din      (s_reg.rx_sync),
		.vote     (vote)
	);

	logic [4:0] spb;
	logic [4:0] first_vote;
	logic [4:0] last_vote;

	always_comb begin
		spb = s_reg.dbl ? uart_rx_pkg::samples_double : uart_rx_pkg::samples_normal;
		first_vote = s_reg.dbl ? uart_rx_pkg::first_vote_double : uart_rx_pkg::first_vote_normal;
		last_vote = first_vote + uart_rx_pkg::vote_span;
		in_window = (s_reg.state != uart_rx_pkg::rx_idle) && (s_reg.cnt >= first_vote) &&
			(s_reg.cnt <= last_vote);
	end

	always_comb begin
		logic       decide;
		logic       setup;
		logic       access;
		logic       ev_complete;
		logic       ev_frame;
		logic       ev_parity;
		logic       ev_overflow;
		logic       data_read;
		logic [3:0] n_data;
		logic [3:0] stat_clear;
		logic [3:0] events;
		decide = 1'b0;
		setup = 1'b0;
		access = 1'b0;
		ev_complete = 1'b0;
		ev_frame = 1'b0;
		ev_parity = 1'b0;
		ev_overflow = 1'b0;
		data_read = 1'b0;
		n_data = 4'h0;
		stat_clear = 4'h0;
		events = 4'h0;
		s_next = s_reg;

		// two-stage synchroniser; only the second stage feeds the receiver
		s_next.rx_meta = rxd;
		s_next.rx_sync = s_reg.rx_meta;

		n_data = char_bits(s_reg.csize);
		decide = sample_tick && (s_reg.cnt == last_vote);

		// apb phases: answer is prepared in setup, taken at the first access edge
		setup = psel & ~penable;
		access = psel & penable & s_reg.pready;
		data_read = access & ~pwrite & (paddr == uart_rx_pkg::data_offset);

		if (sample_tick) begin
			if (s_reg.state != uart_rx_pkg::rx_idle) begin
				s_next.cnt = (s_reg.cnt == spb) ? 5'h01 : s_reg.cnt + 5'h01;
			end
			unique case (s_reg.state)
				uart_rx_pkg::rx_idle: begin
					s_next.last_sample = s_reg.rx_sync;
					if (s_reg.last_sample && !s_reg.rx_sync) begin
						s_next.state = uart_rx_pkg::rx_start;
						// the detecting tick is sample one, so the next tick takes sample two
						s_next.cnt = 5'h02;
					end
				end
				uart_rx_pkg::rx_start: begin
					if (decide) begin
						if (!vote) begin
							// bit timing is now locked to this start bit
							s_next.state = uart_rx_pkg::rx_data;
							s_next.bit_idx = 4'h0;
							s_next.shift = 9'h000;
						end else begin
							s_next.state = uart_rx_pkg::rx_idle;
							s_next.cnt = 5'h00;
							s_next.last_sample = s_reg.rx_sync;
						end
					end
				end
				uart_rx_pkg::rx_data: begin
					if (decide) begin
						s_next.shift[s_reg.bit_idx] = vote;
						if (s_reg.bit_idx == n_data - 4'h1) begin
							s_next.state = s_reg.par_en ? uart_rx_pkg::rx_parity : uart_rx_pkg::rx_stop;
						end else begin
							s_next.bit_idx = s_reg.bit_idx + 4'h1;
						end
					end
				end
				uart_rx_pkg::rx_parity: begin
					if (decide) begin
						s_next.par_bit = vote;
						s_next.state = uart_rx_pkg::rx_stop;
					end
				end
				uart_rx_pkg::rx_stop: begin
					if (decide) begin
						// back to idle at the last vote sample, so an early next start edge is caught
						s_next.state = uart_rx_pkg::rx_idle;
						s_next.cnt = 5'h00;
						s_next.last_sample = s_reg.rx_sync;
						ev_complete = 1'b1;
						ev_frame = ~vote;
						ev_parity = s_reg.par_en & (s_reg.par_bit != (^s_reg.shift ^ s_reg.par_odd));
						ev_overflow = s_reg.buf_full & ~data_read;
						s_next.rx_buf = s_reg.shift;
					end
				end
			endcase
		end

		// receive buffer occupancy; a frame landing with the read keeps the buffer full
		if (ev_complete) begin
			s_next.buf_full = 1'b1;
		end else if (data_read) begin
			s_next.buf_full = 1'b0;
		end

		// status read clears only the bits it returned; new events win over the clear
		if (access && !pwrite && paddr == uart_rx_pkg::status_offset) begin
			stat_clear = s_reg.prdata[3:0];
		end
		events[uart_rx_pkg::stat_complete_bit] = ev_complete;
		events[uart_rx_pkg::stat_frame_bit] = ev_frame;
		events[uart_rx_pkg::stat_parity_bit] = ev_parity;
		events[uart_rx_pkg::stat_overflow_bit] = ev_overflow;
		s_next.status = (s_reg.status & ~stat_clear) | events;

		if (access && pwrite) begin
			unique case (paddr)
				uart_rx_pkg::ctrl_offset: begin
					s_next.rx_en = pwdata[uart_rx_pkg::ctrl_rx_enable_bit];
					s_next.dbl = pwdata[uart_rx_pkg::ctrl_double_bit];
					s_next.par_en = pwdata[uart_rx_pkg::ctrl_parity_en_bit];
					s_next.par_odd = pwdata[uart_rx_pkg::ctrl_parity_odd_bit];
					s_next.csize = pwdata[uart_rx_pkg::ctrl_char_msb:uart_rx_pkg::ctrl_char_lsb];
				end
				uart_rx_pkg::baud_offset: begin
					s_next.baud_sel = pwdata[uart_rx_pkg::baud_select_msb:uart_rx_pkg::baud_select_lsb];
					s_next.scale = pwdata[uart_rx_pkg::baud_scale_msb:uart_rx_pkg::baud_scale_lsb];
				end
				uart_rx_pkg::mask_offset: begin
					s_next.mask = pwdata[3:0];
				end
				default: begin
				end
			endcase
		end

		// disabling is immediate: reception is abandoned and the buffer flushed
		if (!s_next.rx_en) begin
			s_next.state = uart_rx_pkg::rx_idle;
			s_next.cnt = 5'h00;
			s_next.last_sample = 1'b0;
			s_next.buf_full = 1'b0;
		end

		s_next.pready = setup;
		s_next.pslverr = setup & ~is_mapped(paddr);
		if (setup) begin
			s_next.prdata = 32'h00000000;
			if (!pwrite) begin
				unique case (paddr)
					uart_rx_pkg::ctrl_offset: begin
						s_next.prdata[uart_rx_pkg::ctrl_rx_enable_bit] = s_reg.rx_en;
						s_next.prdata[uart_rx_pkg::ctrl_double_bit] = s_reg.dbl;
						s_next.prdata[uart_rx_pkg::ctrl_parity_en_bit] = s_reg.par_en;
						s_next.prdata[uart_rx_pkg::ctrl_parity_odd_bit] = s_reg.par_odd;
						s_next.prdata[uart_rx_pkg::ctrl_char_msb:uart_rx_pkg::ctrl_char_lsb] = s_reg.csize;
					end
					uart_rx_pkg::baud_offset: begin
						s_next.prdata[uart_rx_pkg::baud_select_msb:uart_rx_pkg::baud_select_lsb] = s_reg.baud_sel;
						s_next.prdata[uart_rx_pkg::baud_scale_msb:uart_rx_pkg::baud_scale_lsb] = s_reg.scale;
					end
					uart_rx_pkg::status_offset: begin
						s_next.prdata[3:0] = s_reg.status;
						s_next.prdata[uart_rx_pkg::stat_full_bit] = s_reg.buf_full;
					end
					uart_rx_pkg::mask_offset: begin
						s_next.prdata[3:0] = s_reg.mask;
					end
					uart_rx_pkg::data_offset: begin
						s_next.prdata[8:0] = s_reg.rx_buf;
					end
					default: begin
					end
				endcase
			end
		end

		s_next.irq = |(s_next.status & s_next.mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.rx_meta <= 1'b1;
			s_reg.rx_sync <= 1'b1;
			s_reg.state <= uart_rx_pkg::rx_idle;
			s_reg.csize <= uart_rx_pkg::char_size_reset;
			s_reg.baud_sel <= uart_rx_pkg::baud_sel_reset;
			s_reg.scale <= uart_rx_pkg::baud_scale_reset;
			s_reg.mask <= uart_rx_pkg::mask_reset;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign irq = s_reg.irq;

endmodule

// [testbench/async_rx_chk.sv]
// port checks of the receiver: apb handshake and interrupt gating
`timescale 1ns/10ps
module async_rx_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rxd,
	input wire logic        irq
);
	logic [3:0] mask_q;
	logic       mapped;
	assign mapped = paddr[1:0] == 2'h0 && paddr <= uart_rx_pkg::data_offset;
	// mask shadow follows the completing write edge, as the device does
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mask_q <= 4'h0;
		else if (psel && penable && pready && pwrite && paddr == uart_rx_pkg::mask_offset)
			mask_q <= pwdata[3:0];
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
	a_ready_in_access: assert property (pready |-> psel && penable) else $error("ready outside access");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_unmapped_err: assert property (pready && !mapped |-> pslverr) else $error("unmapped not refused");
	a_mapped_ok: assert property (pready && mapped |-> !pslverr) else $error("mapped refused");
	a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
	a_irq_masked: assert property (irq |-> mask_q != 4'h0 || $past(mask_q) != 4'h0)
		else $error("interrupt while masked");
endmodule

// [testbench/uart_tx_model.sv]
// behavioural remote transmitter driving the receive line
`timescale 1ns/10ps
module uart_tx_model (
	input wire logic pclk,
	output logic     rxd
);
	initial rxd = 1'b1;
	// levels change right after an edge; cyc sets the sender's own bit rate
	task automatic send(input logic [9:0] b, input int n, input int cyc, input int sc, input logic sp);
		@(posedge pclk);
		rxd <= 1'b0;
		repeat (cyc) @(posedge pclk);
		for (int i = 0; i < n; i++) begin
			rxd <= b[i];
			repeat (cyc) @(posedge pclk);
		end
		rxd <= sp;
		repeat (sc) @(posedge pclk);
		rxd <= 1'b1;
	endtask
endmodule

// [testbench/async_rx_clock_data_recovery_tb.sv]
// self-checking bench of the oversampling receiver
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
	$display("unexpected at %0t: got %h, expected %h", $time, (a), (e)); end end
module async_rx_clock_data_recovery_tb;
	localparam logic [7:0] ctl_a = uart_rx_pkg::ctrl_offset;
	localparam logic [7:0] bd_a = uart_rx_pkg::baud_offset;
	localparam logic [7:0] st_a = uart_rx_pkg::status_offset;
	localparam logic [7:0] mk_a = uart_rx_pkg::mask_offset;
	localparam logic [7:0] dt_a = uart_rx_pkg::data_offset;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rxd;
	logic        irq;
	logic [31:0] rdata;
	logic        err;
	int          fail_count = 0;
	int          n_compared = 0;
	int          cycles = 0;
	int          lat;
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			end_of_test();
		end
	end
	async_rx_clock_data_recovery i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxd(rxd), .irq(irq));
	uart_tx_model i_tx (.pclk(pclk), .rxd(rxd));
	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// ends once pready is seen; without pready only the bench timeout ends this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rdata, e)
	endtask
	// lat counts from the start edge to the interrupt
	task automatic frame(input logic [9:0] b, input int n, input int cyc, input logic sp, input int lo, input int hi);
		lat = 0;
		fork
			i_tx.send(b, n, cyc, cyc, sp);
			while (irq !== 1'b1 && lat < 1000) begin
				@(posedge pclk);
				lat++;
			end
		join
		`CHK(lat >= lo && lat <= hi, 1'b1)
	endtask
	task automatic got(input logic [31:0] s, input logic [31:0] d);
		rd(st_a, s);
		rd(dt_a, d);
		rd(st_a, 32'h0);
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b0)
	endtask
	task automatic t_regs();
		rd(ctl_a, 32'h30);
		rd(bd_a, 32'h0);
		rd(st_a, 32'h0);
		rd(mk_a, 32'h0);
		rd(8'h14, 32'h0);
		`CHK(err, 1'b1)
		apb(1'b1, mk_a, 32'h7);
		apb(1'b1, ctl_a, 32'h31);
		rd(mk_a, 32'h7);
	endtask
	task automatic t_frames();
		frame(10'h0a5, 8, 16, 1'b1, 150, 165);
		got(32'h11, 32'ha5);
		frame(10'h05a, 8, 16, 1'b0, 150, 165);
		got(32'h13, 32'h5a);
	endtask
	task automatic t_noise();
		i_tx.send(10'h0, 0, 8, 1, 1'b1);
		repeat (200) @(posedge pclk);
		rd(st_a, 32'h0);
		i_tx.send(10'h0, 0, 9, 1, 1'b1);
		repeat (200) @(posedge pclk);
		got(32'h11, 32'hff);
	endtask
	// second start lands right after the stop bit's last vote sample
	task automatic t_b2b();
		i_tx.send(10'h00f, 8, 16, 9, 1'b1);
		i_tx.send(10'h081, 8, 16, 16, 1'b1);
		repeat (20) @(posedge pclk);
		got(32'h19, 32'h81);
	endtask
	task automatic t_parity();
		apb(1'b1, ctl_a, 32'h35);
		frame(10'h007, 9, 16, 1'b1, 165, 182);
		got(32'h15, 32'h07);
		apb(1'b1, ctl_a, 32'h3d);
		frame(10'h007, 9, 16, 1'b1, 165, 182);
		got(32'h11, 32'h07);
	endtask
	task automatic t_double();
		apb(1'b1, ctl_a, 32'h33);
		frame(10'h03c, 8, 8, 1'b1, 74, 88);
		got(32'h11, 32'h3c);
		apb(1'b1, ctl_a, 32'h31);
	endtask
	task automatic t_mask();
		apb(1'b1, mk_a, 32'h0);
		i_tx.send(10'h011, 8, 16, 16, 1'b1);
		repeat (10) @(posedge pclk);
		`CHK(irq, 1'b0)
		apb(1'b1, mk_a, 32'h1);
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b1)
		got(32'h11, 32'h11);
		apb(1'b1, mk_a, 32'h7);
	endtask
	task automatic t_rate();
		apb(1'b1, bd_a, 32'h1);
		frame(10'h0c3, 8, 33, 1'b1, 300, 325);
		got(32'h11, 32'hc3);
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_frames();
		t_noise();
		t_b2b();
		t_parity();
		t_double();
		t_mask();
		t_rate();
		end_of_test();
	end
endmodule
bind async_rx_clock_data_recovery async_rx_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .rxd(rxd), .irq(irq));
